// File: core/sr_pkg.sv
// Constants for the speed ramp and speed detection block.
// Assumes a 40 MHz core clock and a 1 ms control tick.
package sr_pkg;
    // Parameter addresses on the drive's parameter port
    localparam logic [15:0] ADDR_DECEL = 16'h0146;
    localparam logic [15:0] ADDR_SCURVE = 16'h0148;
    localparam logic [15:0] ADDR_INERTIA = 16'h014a;
    localparam logic [15:0] ADDR_ZERO_THR = 16'h014c;
    localparam logic [15:0] ADDR_TARGET = 16'h014e;
    localparam logic [15:0] ADDR_FULL_SCALE = 16'h0150;
    localparam logic [15:0] ADDR_STATUS = 16'h015e;

    // Reset values
    localparam logic [15:0] RST_DECEL = 16'h00c8;
    localparam logic [15:0] RST_SCURVE = 16'h0000;
    localparam logic [15:0] RST_INERTIA = 16'h000a;
    localparam logic [15:0] RST_ZERO_THR = 16'h0064;
    localparam logic [15:0] RST_TARGET = 16'h0bb8;

    // Setting ranges
    localparam logic [15:0] DECEL_MIN = 16'h0001;
    localparam logic [15:0] DECEL_MAX = 16'h4e20;
    localparam logic [15:0] SCURVE_MAX = 16'h2710;
    localparam logic [15:0] INERTIA_MAX = 16'h07d0;
    localparam logic [15:0] ZERO_THR_MAX = 16'h07d0;
    localparam logic [15:0] TARGET_MAX = 16'h1388;
    localparam logic [15:0] FULL_SCALE_MAX = 16'h2710;

    // Status field positions
    localparam int ST_ZERO_BIT = 0;
    localparam int ST_TARGET_BIT = 1;

    // Speed units: measured speed is in 0.1 r/min
    localparam int SPEED_TENTHS = 10;

    // Analog full scale is 10 V, input given in mV
    localparam int ANALOG_FS_V = 10;
    localparam int ANALOG_FS_MV = ANALOG_FS_V * 1000;

    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYC_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // Ramp reference fixed point
    localparam int FRAC_BITS = 16;
    localparam int RAMP_W = 40;

    localparam int RATED_RPM_DEF = 3000;
endpackage : sr_pkg

// File: core/sr_analog_scale.sv
// Scales the analog speed input to r/min by the full-scale setting.
// Assumes the analog sample arrives in mV on the core clock.
`timescale 1ns/1ps
module sr_analog_scale import sr_pkg::*; #(
    parameter int AIN_W = 15,
    parameter int OUT_W = 17
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic signed [AIN_W-1:0] ain_mv,
    input wire logic [15:0] full_scale,
    output logic signed [OUT_W-1:0] speed_rpm
);
    logic signed [AIN_W+16:0] prod;
    logic signed [AIN_W+16:0] quot;

    // Voltage times full scale over ten volts
    always_comb begin
        prod = ain_mv * $signed({1'b0, full_scale});
        quot = prod / (AIN_W+17)'(ANALOG_FS_MV);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            speed_rpm <= '0;
        end else begin
            speed_rpm <= OUT_W'(quot);
        end
    end
endmodule : sr_analog_scale

// File: core/sr_speed_ramp.sv
// Speed profile generator with S-curve and zero/target speed detection.
// Assumes parameter port, speed command and feedback on the core clock.
`timescale 1ns/1ps
// How it works
// - Deceleration ramp time, 1-20000 ms, default 200
// - Speed-up time equals accel plus S-curve
// - Slow-down time equals decel plus S-curve
// - Zero S-curve disables smoothing only, for digital command
// - Analog command, no S-curve: bypass ramp
// - Zero flag when speed at/below threshold
// - Zero flag clears only strictly above threshold
// - Target flag when speed magnitude reaches target
// - Target flag clears once below target
// - Hold inertia ratio in 0.1 units
// - Hold analog full-scale speed, 0-10000 r/min
// - Analog speed is volts times scale over 10
module sr_speed_ramp import sr_pkg::*; #(
    parameter int RATED_RPM = RATED_RPM_DEF,
    parameter int TICK_CYC = TICK_CYC_DEF,
    parameter int AIN_W = 15,
    parameter int SPD_W = 20
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic par_wr,
    input wire logic par_rd,
    input wire logic [15:0] par_addr,
    input wire logic [15:0] par_wdata,
    output logic [15:0] par_rdata,
    output logic par_err,
    input wire logic [15:0] accel_time_ms,
    input wire logic signed [15:0] cmd_speed,
    input wire logic cmd_src_analog,
    input wire logic signed [AIN_W-1:0] ain_mv,
    input wire logic signed [SPD_W-1:0] motor_speed,
    output logic signed [16:0] speed_ref,
    output logic zero_speed_flag,
    output logic target_speed_reached
);
    localparam logic [15:0] RATED_W = 16'(RATED_RPM);
    localparam logic [RAMP_W-1:0] RATED_Q = RAMP_W'(RATED_RPM) << FRAC_BITS;

    logic [15:0] decel_time_ff;
    logic [15:0] scurve_time_ff;
    logic [15:0] inertia_ratio_ff;
    logic [15:0] zero_thr_ff;
    logic [15:0] target_speed_setting_ff;
    logic [15:0] analog_full_scale_ff;
    logic [31:0] tick_cnt_ff;
    logic tick_ff;
    logic signed [RAMP_W-1:0] ref_ff;
    logic [RAMP_W-1:0] rate_ff;
    logic [15:0] jcnt_ff;
    logic signed [16:0] analog_rpm;
    logic signed [16:0] cmd_sel;
    logic signed [RAMP_W-1:0] tgt;
    logic signed [RAMP_W-1:0] err;
    logic [RAMP_W-1:0] err_mag;
    logic away;
    logic [RAMP_W-1:0] full_step;
    logic [RAMP_W-1:0] jerk_step;
    logic [RAMP_W-1:0] unwind;
    logic [RAMP_W-1:0] nxt_rate;
    logic [15:0] nxt_jcnt;
    logic signed [RAMP_W-1:0] nxt_ref;
    logic bypass;
    logic [SPD_W-1:0] spd_mag;
    logic [SPD_W+3:0] target_tenths;
    logic wr_ok;

    // Range check on written values; out-of-range writes are refused
    function automatic logic in_range(input logic [15:0] addr, input logic [15:0] val);
        case (addr)
            ADDR_DECEL: in_range = (val >= DECEL_MIN) && (val <= DECEL_MAX);
            ADDR_SCURVE: in_range = val <= SCURVE_MAX;
            ADDR_INERTIA: in_range = val <= INERTIA_MAX;
            ADDR_ZERO_THR: in_range = val <= ZERO_THR_MAX;
            ADDR_TARGET: in_range = val <= TARGET_MAX;
            ADDR_FULL_SCALE: in_range = val <= FULL_SCALE_MAX;
            default: in_range = 1'b0;
        endcase
    endfunction : in_range

    // Ramp step per tick for a full 0-to-rated sweep in ms ticks
    function automatic logic [RAMP_W-1:0] step_of(input logic [15:0] ms);
        logic [RAMP_W-1:0] den;
        den = (ms == 16'h0000) ? RAMP_W'(1) : RAMP_W'(ms);
        step_of = RATED_Q / den;
    endfunction : step_of

    assign wr_ok = par_wr && in_range(par_addr, par_wdata);

    // Parameter storage
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            decel_time_ff <= RST_DECEL;
            scurve_time_ff <= RST_SCURVE;
            inertia_ratio_ff <= RST_INERTIA;
            zero_thr_ff <= RST_ZERO_THR;
            target_speed_setting_ff <= RST_TARGET;
            analog_full_scale_ff <= RATED_W;
        end else if (wr_ok) begin
            case (par_addr)
                ADDR_DECEL: decel_time_ff <= par_wdata;
                ADDR_SCURVE: scurve_time_ff <= par_wdata;
                ADDR_INERTIA: inertia_ratio_ff <= par_wdata;
                ADDR_ZERO_THR: zero_thr_ff <= par_wdata;
                ADDR_TARGET: target_speed_setting_ff <= par_wdata;
                ADDR_FULL_SCALE: analog_full_scale_ff <= par_wdata;
                default: ;
            endcase
        end
    end

    // Read path and refusal flag, answered the cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            par_rdata <= 16'h0000;
            par_err <= 1'b0;
        end else begin
            par_err <= par_wr && !wr_ok;
            if (par_rd) begin
                par_err <= 1'b0;
                case (par_addr)
                    ADDR_DECEL: par_rdata <= decel_time_ff;
                    ADDR_SCURVE: par_rdata <= scurve_time_ff;
                    ADDR_INERTIA: par_rdata <= inertia_ratio_ff;
                    ADDR_ZERO_THR: par_rdata <= zero_thr_ff;
                    ADDR_TARGET: par_rdata <= target_speed_setting_ff;
                    ADDR_FULL_SCALE: par_rdata <= analog_full_scale_ff;
                    ADDR_STATUS: begin
                        par_rdata <= 16'h0000;
                        par_rdata[ST_ZERO_BIT] <= zero_speed_flag;
                        par_rdata[ST_TARGET_BIT] <= target_speed_reached;
                    end
                    default: begin
                        par_rdata <= 16'h0000;
                        par_err <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Control tick, 1 ms
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else if (tick_cnt_ff == 32'(TICK_CYC - 1)) begin
            tick_cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
            tick_ff <= 1'b0;
        end
    end

    sr_analog_scale #(
        .AIN_W(AIN_W),
        .OUT_W(17)
    ) u_scale (
        .ref_clk(ref_clk),
        .rst(rst),
        .ain_mv(ain_mv),
        .full_scale(analog_full_scale_ff),
        .speed_rpm(analog_rpm)
    );

    // Ramp next state
    always_comb begin
        cmd_sel = cmd_src_analog ? analog_rpm : 17'(cmd_speed);
        tgt = RAMP_W'(cmd_sel) <<< FRAC_BITS;
        err = tgt - ref_ff;
        err_mag = err[RAMP_W-1] ? RAMP_W'(-err) : RAMP_W'(err);
        // Magnitude grows when moving away from zero
        away = err[RAMP_W-1] ? (ref_ff <= 0) : (ref_ff >= 0);
        full_step = away ? step_of(accel_time_ms) : step_of(decel_time_ff);
        jerk_step = full_step / RAMP_W'(scurve_time_ff | 16'h0001);
        if (jerk_step == '0) begin
            jerk_step = RAMP_W'(1);
        end
        // Distance still covered while the rate winds back to zero
        unwind = RAMP_W'((rate_ff * RAMP_W'(jcnt_ff)) >> 1);
        nxt_jcnt = jcnt_ff;
        if (scurve_time_ff == 16'h0000) begin
            // Linear ramp stays in force without smoothing
            nxt_rate = full_step;
            nxt_jcnt = 16'h0000;
        end else if (err_mag <= unwind) begin
            // Rate eases off so the curve rounds into the command
            nxt_rate = (rate_ff > jerk_step) ? rate_ff - jerk_step : jerk_step;
            nxt_jcnt = (jcnt_ff != 16'h0000) ? jcnt_ff - 16'h0001 : 16'h0000;
        end else if (rate_ff + jerk_step < full_step) begin
            // Rate builds over the S-curve time, lengthening the profile by it
            nxt_rate = rate_ff + jerk_step;
            nxt_jcnt = jcnt_ff + 16'h0001;
        end else begin
            nxt_rate = full_step;
        end
        if (err_mag <= nxt_rate) begin
            nxt_ref = tgt;
            nxt_rate = '0;
            nxt_jcnt = 16'h0000;
        end else if (err[RAMP_W-1]) begin
            nxt_ref = ref_ff - $signed(nxt_rate);
        end else begin
            nxt_ref = ref_ff + $signed(nxt_rate);
        end
        bypass = cmd_src_analog && (scurve_time_ff == 16'h0000);
    end

    // Ramp state, updated once per tick, or every cycle in bypass
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ref_ff <= '0;
            rate_ff <= '0;
            jcnt_ff <= 16'h0000;
        end else if (bypass) begin
            // Shaping skipped entirely for analog command with zero S-curve
            ref_ff <= tgt;
            rate_ff <= '0;
            jcnt_ff <= 16'h0000;
        end else if (tick_ff) begin
            ref_ff <= nxt_ref;
            rate_ff <= nxt_rate;
            jcnt_ff <= nxt_jcnt;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            speed_ref <= '0;
        end else begin
            speed_ref <= 17'(ref_ff >>> FRAC_BITS);
        end
    end

    // Speed detection
    always_comb begin
        spd_mag = motor_speed[SPD_W-1] ? SPD_W'(-motor_speed) : SPD_W'(motor_speed);
        target_tenths = (SPD_W+4)'(target_speed_setting_ff) * (SPD_W+4)'(SPEED_TENTHS);
    end

    // Same boundary sets and clears, so the flag tracks the comparison
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            zero_speed_flag <= 1'b0;
        end else if ((SPD_W+4)'(spd_mag) <= (SPD_W+4)'(zero_thr_ff)) begin
            zero_speed_flag <= 1'b1;
        end else begin
            zero_speed_flag <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            target_speed_reached <= 1'b0;
        end else if ((SPD_W+4)'(spd_mag) >= target_tenths) begin
            target_speed_reached <= 1'b1;
        end else begin
            target_speed_reached <= 1'b0;
        end
    end
endmodule : sr_speed_ramp

// File: bench/sr_chk.sv
// Port checker for sr_speed_ramp.
// Assumes thresholds change only through the parameter port.
`timescale 1ns/1ps
module sr_chk import sr_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic par_wr,
    input wire logic par_rd,
    input wire logic [15:0] par_addr,
    input wire logic [15:0] par_wdata,
    input wire logic [15:0] par_rdata,
    input wire logic par_err,
    input wire logic cmd_src_analog,
    input wire logic signed [14:0] ain_mv,
    input wire logic signed [19:0] motor_speed,
    input wire logic signed [16:0] speed_ref,
    input wire logic zero_speed_flag,
    input wire logic target_speed_reached
);
    logic [15:0] zthr_ff, tthr_ff, sc_ff, fs_ff;
    logic [19:0] mag;
    logic ok_wr, mapped, live_ff;
    int exp_an;
    assign mag = motor_speed[19] ? -motor_speed : motor_speed;
    // Decided by address alone, so leftover write data cannot change it
    assign mapped = par_addr inside {ADDR_DECEL, ADDR_SCURVE, ADDR_INERTIA, ADDR_ZERO_THR,
        ADDR_TARGET, ADDR_FULL_SCALE, ADDR_STATUS};
    // Truncates toward zero, as the scaling does
    assign exp_an = (int'(ain_mv) * int'(fs_ff)) / ANALOG_FS_MV;
    always_comb begin
        case (par_addr)
            ADDR_DECEL: ok_wr = par_wdata >= DECEL_MIN && par_wdata <= DECEL_MAX;
            ADDR_SCURVE: ok_wr = par_wdata <= SCURVE_MAX;
            ADDR_INERTIA: ok_wr = par_wdata <= INERTIA_MAX;
            ADDR_ZERO_THR: ok_wr = par_wdata <= ZERO_THR_MAX;
            ADDR_TARGET: ok_wr = par_wdata <= TARGET_MAX;
            ADDR_FULL_SCALE: ok_wr = par_wdata <= FULL_SCALE_MAX;
            default: ok_wr = 1'b0;
        endcase
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            zthr_ff <= RST_ZERO_THR;
            tthr_ff <= RST_TARGET;
            sc_ff <= RST_SCURVE;
            fs_ff <= 16'(RATED_RPM_DEF);
        end else if (par_wr && ok_wr) begin
            if (par_addr == ADDR_ZERO_THR) zthr_ff <= par_wdata;
            if (par_addr == ADDR_TARGET) tthr_ff <= par_wdata;
            if (par_addr == ADDR_SCURVE) sc_ff <= par_wdata;
            if (par_addr == ADDR_FULL_SCALE) fs_ff <= par_wdata;
        end
    end
    // Flags first follow the inputs one edge after release, so that edge is not judged
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            live_ff <= 1'b0;
        end else begin
            live_ff <= 1'b1;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst || !live_ff);
    a_zero_set: assert property (!par_wr && mag <= 20'(zthr_ff) |=> zero_speed_flag)
        else $error("zero flag missing");
    a_zero_clear: assert property (!par_wr && mag > 20'(zthr_ff) |=> !zero_speed_flag)
        else $error("zero flag stuck");
    a_target_set: assert property (!par_wr && mag >= 20'(tthr_ff) * 20'd10
        |=> target_speed_reached) else $error("target flag missing");
    a_target_clear: assert property (!par_wr && mag < 20'(tthr_ff) * 20'd10
        |=> !target_speed_reached) else $error("target flag stuck");
    a_bad_write: assert property (par_wr && !ok_wr |=> par_err)
        else $error("bad write not refused");
    a_good_write: assert property (par_wr && ok_wr |=> !par_err)
        else $error("good write refused");
    a_unmapped_read: assert property (par_rd && !mapped |=> par_err && par_rdata == 16'h0000)
        else $error("unmapped read not flagged");
    a_rdata_hold: assert property (!par_rd |=> $stable(par_rdata))
        else $error("read data moved");
    a_analog_bypass: assert property ((cmd_src_analog && sc_ff == 16'h0000 && !par_wr
        && $stable(ain_mv))[*4] |-> speed_ref == 17'(exp_an)) else $error("bypass value");
    c_zero_drop: cover property (zero_speed_flag ##1 !zero_speed_flag);
    c_target_rise: cover property (!target_speed_reached ##1 target_speed_reached);
    c_refused: cover property (par_err);
endmodule : sr_chk

// File: bench/sr_motor_model.sv
// Motor and speed feedback stand-in.
// Assumes the bench sets the speed; one cycle of sensing lag.
`timescale 1ns/1ps
module sr_motor_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic signed [19:0] set_speed,
    output logic signed [19:0] motor_speed
);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            motor_speed <= 20'sh00000;
        end else begin
            motor_speed <= set_speed;
        end
    end
endmodule : sr_motor_model

// File: bench/tb_sr_speed_ramp.sv
// Bench for sr_speed_ramp: parameters, flags, ramps, analog path.
// Assumes sr_chk and sr_motor_model are compiled first.
`timescale 1ns/1ps
module tb_sr_speed_ramp import sr_pkg::*; ;
    logic ref_clk = 1'b0, rst = 1'b1, par_wr = 1'b0, par_rd = 1'b0, src_an = 1'b0;
    logic par_err, zero_f, targ_f;
    logic [15:0] par_addr = '0, par_wdata = '0, par_rdata, accel = 16'h0028;
    logic signed [15:0] cmd = '0;
    logic signed [14:0] ain = '0;
    logic signed [19:0] set_spd = '0, motor_speed;
    logic signed [16:0] speed_ref;
    int err_count = 0, checked = 0, n;
    logic [15:0] ra[6] = '{ADDR_DECEL, ADDR_SCURVE, ADDR_INERTIA, ADDR_ZERO_THR, ADDR_TARGET,
        ADDR_FULL_SCALE};
    logic [15:0] rv[6] = '{16'h00c8, 16'h0000, 16'h000a, 16'h0064, 16'h0bb8, 16'h0bb8};
    logic [15:0] wa[11] = '{ADDR_DECEL, ADDR_DECEL, ADDR_DECEL, ADDR_SCURVE, ADDR_INERTIA,
        ADDR_INERTIA, ADDR_ZERO_THR, ADDR_TARGET, ADDR_FULL_SCALE, ADDR_STATUS, 16'h0152};
    logic [15:0] wd[11] = '{16'h0000, 16'h4e21, 16'h4e20, 16'h2711, 16'h07d1, 16'h000f,
        16'h07d1, 16'h1389, 16'h2711, 16'h0000, 16'h0005};
    logic we[11] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    // Small tick keeps each ramp to a few hundred cycles
    sr_speed_ramp #(.TICK_CYC(8)) u_dut (.ref_clk(ref_clk), .rst(rst), .par_wr(par_wr),
        .par_rd(par_rd), .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata(par_rdata),
        .par_err(par_err), .accel_time_ms(accel), .cmd_speed(cmd), .cmd_src_analog(src_an),
        .ain_mv(ain), .motor_speed(motor_speed), .speed_ref(speed_ref),
        .zero_speed_flag(zero_f), .target_speed_reached(targ_f));
    sr_motor_model u_mot (.ref_clk(ref_clk), .rst(rst), .set_speed(set_spd),
        .motor_speed(motor_speed));
    always #12.5 ref_clk = ~ref_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic acc(input logic rd, input logic [15:0] a, input logic [15:0] d,
            input logic [15:0] e, input logic er);
        @(posedge ref_clk);
        par_wr <= !rd;
        par_rd <= rd;
        par_addr <= a;
        par_wdata <= d;
        @(posedge ref_clk);
        par_wr <= 1'b0;
        par_rd <= 1'b0;
        @(negedge ref_clk);
        chk(par_err, er);
        if (rd) chk(par_rdata, e);
    endtask : acc
    task automatic spd(input logic signed [19:0] v, input logic z, input logic t);
        @(posedge ref_clk);
        set_spd <= v;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(zero_f, z);
        chk(targ_f, t);
    endtask : spd
    // Tick phase is unknown, so ramp times carry a window
    task automatic ramp(input logic signed [15:0] c, input int lo, input int hi);
        @(posedge ref_clk);
        cmd <= c;
        n = 0;
        // Sampled off the edge that updates the reference
        @(negedge ref_clk);
        while (speed_ref !== 17'(c) && n < 4000) begin
            @(negedge ref_clk);
            n++;
        end
        chk(n >= lo && n <= hi, 1'b1);
        if (n == 4000) tally_and_finish();
    endtask : ramp
    task automatic an(input logic signed [14:0] v, input logic signed [16:0] e);
        @(posedge ref_clk);
        ain <= v;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(speed_ref, e);
    endtask : an
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) acc(1, ra[i], 0, rv[i], 0);
        for (int i = 0; i < 11; i++) acc(0, wa[i], wd[i], 0, we[i]);
        acc(1, ADDR_DECEL, 0, 16'h4e20, 0);
        acc(1, ADDR_INERTIA, 0, 16'h000f, 0);
        acc(1, 16'h0152, 0, 16'h0000, 1);
        $display("test params done");
        spd(20'sd100, 1, 0);
        spd(20'sd101, 0, 0);
        spd(-20'sd100, 1, 0);
        spd(20'sd30000, 0, 1);
        spd(-20'sd30000, 0, 1);
        acc(1, ADDR_STATUS, 0, 16'h0002, 0);
        spd(20'sd29999, 0, 0);
        $display("test flags done");
        acc(0, ADDR_DECEL, 16'h0014, 0, 0);
        ramp(3000, 312, 336);
        ramp(0, 152, 176);
        acc(0, ADDR_SCURVE, 16'h000a, 0, 0);
        ramp(3000, 376, 432);
        ramp(0, 216, 272);
        acc(0, ADDR_SCURVE, 0, 0, 0);
        $display("test ramps done");
        @(posedge ref_clk);
        src_an <= 1'b1;
        an(15'sd5000, 17'sd1500);
        acc(0, ADDR_FULL_SCALE, 16'h2710, 0, 0);
        an(-15'sd2500, -17'sd2500);
        $display("test analog done");
        tally_and_finish();
    end
endmodule : tb_sr_speed_ramp
bind sr_speed_ramp sr_chk u_chk (.ref_clk(ref_clk), .rst(rst), .par_wr(par_wr),
    .par_rd(par_rd), .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata(par_rdata),
    .par_err(par_err), .cmd_src_analog(cmd_src_analog), .ain_mv(ain_mv),
    .motor_speed(motor_speed), .speed_ref(speed_ref), .zero_speed_flag(zero_speed_flag),
    .target_speed_reached(target_speed_reached));
